// >>> verilog/pwr_clk_pkg.sv
// constants shared by the power, clock and wakeup control block
package pwr_clk_pkg;

  // ==========================================================
  // register offsets on the special-function bus
  localparam logic [7:0] OFF_POWER_CONTROL = 8'h87;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'hA3;
  localparam logic [7:0] OFF_POWER_DOWN = 8'hA4;
  localparam logic [7:0] OFF_WAKEUP_CONFIG = 8'hA5;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'hB1;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h80;
  localparam logic [7:0] RST_WAKEUP_CONFIG = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ==========================================================
  // field positions
  localparam int CLK_PLL_ENABLE_BIT = 7;
  localparam int CLK_PLL_SEL_HI = 6;
  localparam int CLK_PLL_SEL_LO = 4;
  localparam int CLK_OSC_SEL_HI = 1;
  localparam int CLK_OSC_SEL_LO = 0;
  localparam int PD_LOW_FREQ_BIT = 3;
  localparam int PD_STANDBY_HI = 2;
  localparam int PD_STANDBY_LO = 0;
  localparam int CAUSE_WATCHDOG_BIT = 0;
  localparam int WU_RADIO_LO = 6;
  localparam int WU_INTERNAL_LO = 4;
  localparam int WU_USB_LO = 2;
  localparam int WU_USB_RESUME_LO = 0;
  localparam int PC_BAUD_DOUBLE_BIT = 7;
  localparam int PC_FLAG_THREE_BIT = 6;
  localparam int PC_FLAG_TWO_BIT = 5;
  localparam int PC_PROG_WRITE_BIT = 4;
  localparam int PC_FLAG_ONE_BIT = 3;
  localparam int PC_FLAG_ZERO_BIT = 2;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_IDLE_BIT = 0;

  // bits of the core's second interrupt enable register
  localparam int IEN_RADIO_BIT = 1;
  localparam int IEN_USB_RESUME_BIT = 3;
  localparam int IEN_USB_BIT = 4;
  localparam int IEN_INTERNAL_BIT = 5;

  // ==========================================================
  // wakeup source handling codes
  localparam logic [1:0] WU_IF_ENABLED = 2'h0;
  localparam logic [1:0] WU_RESERVED = 2'h1;
  localparam logic [1:0] WU_ALWAYS = 2'h2;
  localparam logic [1:0] WU_IGNORE = 2'h3;

  // ==========================================================
  // clock frequencies in kHz
  localparam logic [15:0] OSC_KHZ = 16'h3E80;   // 16 MHz oscillator
  localparam logic [1:0] PLL_FACTOR = 2'h3;
  localparam logic [15:0] PLL_OFF_KHZ = 16'h0000;
  localparam logic [15:0] F16M_KHZ = 16'h3E80;
  localparam logic [15:0] F12M_KHZ = 16'h2EE0;
  localparam logic [15:0] F8M_KHZ = 16'h1F40;
  localparam logic [15:0] F4M_KHZ = 16'h0FA0;
  localparam logic [15:0] F1M6_KHZ = 16'h0640;
  localparam logic [15:0] F320K_KHZ = 16'h0140;
  localparam logic [15:0] F64K_KHZ = 16'h0040;

  // ==========================================================
  // start-up sequence timing, mclk at 200 MHz
  localparam int MCLK_MHZ = 200;
  localparam int STARTUP_NS = 100;
  localparam int STARTUP_CYCLES = (STARTUP_NS * MCLK_MHZ + 999) / 1000;
  localparam int SEQ_W = 8;
  localparam logic [SEQ_W-1:0] SEQ_LOAD = SEQ_W'(STARTUP_CYCLES);

  // mcu power state
  typedef enum logic [1:0] {
    MCU_ACTIVE = 2'b01,
    MCU_STANDBY = 2'b10
  } mcu_state_e;

endpackage

// >>> verilog/wake_source_gate.sv
// one wakeup source gated by its two-bit handling code
`timescale 1ns/1ps

module wake_source_gate (
  // configuration
  input wire logic [1:0] mode,
  input wire logic intEnable,
  // event and result
  input wire logic srcEvent,
  output logic wake
);

  // reserved and ignore codes never wake
  always_comb begin
    case (mode)
      pwr_clk_pkg::WU_IF_ENABLED: wake = srcEvent & intEnable;
      pwr_clk_pkg::WU_ALWAYS: wake = srcEvent;
      default: wake = 1'b0;
    endcase
  end

endmodule

// >>> verilog/power_clock_wakeup_control.sv
// power, clock selection, reset cause and wakeup control registers
//
// Behaviour
// - clock control top bit enables PLL
// - PLL on: bits 6:4 pick MCU clock
// - PLL off: bits 1:0 pick MCU clock
// - power-down bit 3 reads low-frequency clock
// - nonzero power-down bits 2:0 write enters standby
// - all reset sources share one sequence
// - reset cause bit 0 marks watchdog
// - wakeup bits 7:6 handle radio interrupt
// - wakeup bits 5:4 handle internal wakeup
// - wakeup bits 3:2 handle USB interrupt
// - wakeup bits 1:0 handle USB resume
// - power control bit 7 doubles baud
// - power control bits 6,5,3,2 plain flags
// - power control bit 4 enables program write
// - power control bit 1 stops core
// - power control bit 0 idles core
// - PLL gives oscillator times three
// - software PLL bit only during USB suspend
// - permitted events restart stopped MCU clock
`timescale 1ns/1ps

module power_clock_wakeup_control (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // register port from the core
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // other reset sources
  input wire logic resetPinN,
  input wire logic watchdogReset,
  // always-running low-frequency clock, asynchronous here
  input wire logic lowFreqClock,
  // usb state
  input wire logic usbSuspended,
  // wakeup events and the core's enable register
  input wire logic rfIrq,
  input wire logic internalWakeupEvent,
  input wire logic usbInterrupt,
  input wire logic usbResumeInterrupt,
  input wire logic [7:0] interruptEnableSecond,
  // clock tree control
  output logic pllOn,
  output logic [15:0] pllFreqKhz,
  output logic [15:0] mcuFreqKhz,
  output logic mcuClockRun,
  output logic coreReset,
  // core mode controls
  output logic baudDouble,
  output logic progWriteEnable,
  output logic stopModeReq,
  output logic idleModeReq
);

  // ==========================================================
  // input synchronisers
  logic pinMeta_q;
  logic pinSync_q;
  logic lfMeta_q;
  logic lfSync_q;

  // pin and low-frequency clock come from outside mclk
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      lfMeta_q <= 1'b0;
      lfSync_q <= 1'b0;
    end else begin
      pinMeta_q <= resetPinN;
      pinSync_q <= pinMeta_q;
      lfMeta_q <= lowFreqClock;
      lfSync_q <= lfMeta_q;
    end
  end

  // ==========================================================
  // reset sequence
  logic pinReset;
  logic anyReset;
  logic [pwr_clk_pkg::SEQ_W-1:0] seqCount_q;
  logic coreReset_q;
  logic watchdogCause_q;

  assign pinReset = ~pinSync_q;
  // every source feeds the same request
  assign anyReset = rst | pinReset | watchdogReset;

  // one counter holds the core in reset for the start-up time
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      seqCount_q <= pwr_clk_pkg::SEQ_LOAD;
    end else if (seqCount_q != '0) begin
      seqCount_q <= seqCount_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      coreReset_q <= 1'b1;
    end else begin
      coreReset_q <= (seqCount_q > 1);
    end
  end

  // cause survives the sequence; power-on and pin outrank the watchdog
  always_ff @(posedge mclk) begin
    if (rst | pinReset) begin
      watchdogCause_q <= 1'b0;
    end else if (watchdogReset) begin
      watchdogCause_q <= 1'b1;
    end
  end

  // ==========================================================
  // register decode
  logic wrClock;
  logic wrPowerDown;
  logic wrWakeup;
  logic wrPower;

  assign wrClock = regWr & (regAddr == pwr_clk_pkg::OFF_CLOCK_CONTROL);
  assign wrPowerDown = regWr & (regAddr == pwr_clk_pkg::OFF_POWER_DOWN);
  assign wrWakeup = regWr & (regAddr == pwr_clk_pkg::OFF_WAKEUP_CONFIG);
  assign wrPower = regWr & (regAddr == pwr_clk_pkg::OFF_POWER_CONTROL);

  // ==========================================================
  // clock control register
  logic [7:0] clockControl_q;

  // unused bits 3:2 are not stored
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      clockControl_q <= pwr_clk_pkg::RST_CLOCK_CONTROL;
    end else if (wrClock) begin
      clockControl_q <= regWrData & 8'hF3;
    end
  end

  // ==========================================================
  // pll control
  logic pllOn_q;
  logic swPllEnable;

  assign swPllEnable = clockControl_q[pwr_clk_pkg::CLK_PLL_ENABLE_BIT];

  // hardware keeps the pll on unless usb is suspended
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      pllOn_q <= 1'b1;
    end else begin
      pllOn_q <= usbSuspended ? swPllEnable : 1'b1;
    end
  end

  // pll output reported as oscillator times the factor
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      pllFreqKhz <= 16'(pwr_clk_pkg::OSC_KHZ * pwr_clk_pkg::PLL_FACTOR);
    end else if (pllOn_q) begin
      pllFreqKhz <= 16'(pwr_clk_pkg::OSC_KHZ * pwr_clk_pkg::PLL_FACTOR);
    end else begin
      pllFreqKhz <= pwr_clk_pkg::PLL_OFF_KHZ;
    end
  end

  assign pllOn = pllOn_q;

  // ==========================================================
  // mcu clock selection
  logic [2:0] pllSel;
  logic [1:0] oscSel;
  logic [15:0] pllPathKhz;
  logic pllPathValid;
  logic [15:0] oscPathKhz;

  assign pllSel = clockControl_q[pwr_clk_pkg::CLK_PLL_SEL_HI:pwr_clk_pkg::CLK_PLL_SEL_LO];
  assign oscSel = clockControl_q[pwr_clk_pkg::CLK_OSC_SEL_HI:pwr_clk_pkg::CLK_OSC_SEL_LO];

  // pll path divider codes
  always_comb begin
    pllPathValid = 1'b1;
    case (pllSel)
      3'h0: pllPathKhz = pwr_clk_pkg::F16M_KHZ;
      3'h1: pllPathKhz = pwr_clk_pkg::F12M_KHZ;
      3'h2: pllPathKhz = pwr_clk_pkg::F8M_KHZ;
      3'h3: pllPathKhz = pwr_clk_pkg::F4M_KHZ;
      3'h4: pllPathKhz = pwr_clk_pkg::F1M6_KHZ;
      default: begin
        pllPathKhz = pwr_clk_pkg::F16M_KHZ;
        pllPathValid = 1'b0;
      end
    endcase
  end

  // oscillator path divider codes, all four defined
  always_comb begin
    case (oscSel)
      2'h0: oscPathKhz = pwr_clk_pkg::F4M_KHZ;
      2'h1: oscPathKhz = pwr_clk_pkg::F1M6_KHZ;
      2'h2: oscPathKhz = pwr_clk_pkg::F320K_KHZ;
      default: oscPathKhz = pwr_clk_pkg::F64K_KHZ;
    endcase
  end

  // a reserved pll code keeps the last good divider so the core never
  // sees an undefined clock; standby does not touch the selection
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      mcuFreqKhz <= pwr_clk_pkg::F16M_KHZ;
    end else if (pllOn_q) begin
      if (pllPathValid) begin
        mcuFreqKhz <= pllPathKhz;
      end
    end else begin
      mcuFreqKhz <= oscPathKhz;
    end
  end

  // ==========================================================
  // wakeup configuration register
  logic [7:0] wakeupConfig_q;

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      wakeupConfig_q <= pwr_clk_pkg::RST_WAKEUP_CONFIG;
    end else if (wrWakeup) begin
      wakeupConfig_q <= regWrData;
    end
  end

  // ==========================================================
  // per-source wakeup gating
  logic wakeRadio;
  logic wakeInternal;
  logic wakeUsb;
  logic wakeUsbResume;
  logic wakeAny;

  // radio interrupt
  wake_source_gate u_wake_radio (
    .mode(wakeupConfig_q[pwr_clk_pkg::WU_RADIO_LO+1:pwr_clk_pkg::WU_RADIO_LO]),
    .intEnable(interruptEnableSecond[pwr_clk_pkg::IEN_RADIO_BIT]),
    .srcEvent(rfIrq),
    .wake(wakeRadio)
  );

  // internal wakeup from pins and timer
  wake_source_gate u_wake_internal (
    .mode(wakeupConfig_q[pwr_clk_pkg::WU_INTERNAL_LO+1:pwr_clk_pkg::WU_INTERNAL_LO]),
    .intEnable(interruptEnableSecond[pwr_clk_pkg::IEN_INTERNAL_BIT]),
    .srcEvent(internalWakeupEvent),
    .wake(wakeInternal)
  );

  // usb interrupt
  wake_source_gate u_wake_usb (
    .mode(wakeupConfig_q[pwr_clk_pkg::WU_USB_LO+1:pwr_clk_pkg::WU_USB_LO]),
    .intEnable(interruptEnableSecond[pwr_clk_pkg::IEN_USB_BIT]),
    .srcEvent(usbInterrupt),
    .wake(wakeUsb)
  );

  // usb resume interrupt
  wake_source_gate u_wake_usb_resume (
    .mode(wakeupConfig_q[pwr_clk_pkg::WU_USB_RESUME_LO+1:pwr_clk_pkg::WU_USB_RESUME_LO]),
    .intEnable(interruptEnableSecond[pwr_clk_pkg::IEN_USB_RESUME_BIT]),
    .srcEvent(usbResumeInterrupt),
    .wake(wakeUsbResume)
  );

  assign wakeAny = wakeRadio | wakeInternal | wakeUsb | wakeUsbResume;

  // ==========================================================
  // mcu standby state
  pwr_clk_pkg::mcu_state_e mcuState_q;
  logic standbyReq;

  // only a nonzero code in the low field requests standby
  assign standbyReq = wrPowerDown &
    (regWrData[pwr_clk_pkg::PD_STANDBY_HI:pwr_clk_pkg::PD_STANDBY_LO] != 3'h0);

  // an event still pending at entry wakes one cycle later, which is
  // why software must clear pending interrupts first
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      mcuState_q <= pwr_clk_pkg::MCU_ACTIVE;
    end else begin
      case (mcuState_q)
        pwr_clk_pkg::MCU_ACTIVE: begin
          if (standbyReq) begin
            mcuState_q <= pwr_clk_pkg::MCU_STANDBY;
          end
        end
        pwr_clk_pkg::MCU_STANDBY: begin
          if (wakeAny) begin
            mcuState_q <= pwr_clk_pkg::MCU_ACTIVE;
          end
        end
        default: mcuState_q <= pwr_clk_pkg::MCU_ACTIVE;
      endcase
    end
  end

  assign mcuClockRun = (mcuState_q == pwr_clk_pkg::MCU_ACTIVE);

  // ==========================================================
  // power control register
  logic [7:0] powerControl_q;
  logic stopPulse_q;
  logic idlePulse_q;

  // stop and idle are not stored; they leave a one-cycle request
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      powerControl_q <= pwr_clk_pkg::RST_POWER_CONTROL;
    end else if (wrPower) begin
      powerControl_q <= regWrData & 8'hFC;
    end
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      stopPulse_q <= 1'b0;
      idlePulse_q <= 1'b0;
    end else begin
      stopPulse_q <= wrPower & regWrData[pwr_clk_pkg::PC_STOP_BIT];
      idlePulse_q <= wrPower & regWrData[pwr_clk_pkg::PC_IDLE_BIT];
    end
  end

  assign baudDouble = powerControl_q[pwr_clk_pkg::PC_BAUD_DOUBLE_BIT];
  assign progWriteEnable = powerControl_q[pwr_clk_pkg::PC_PROG_WRITE_BIT];
  assign stopModeReq = stopPulse_q;
  assign idleModeReq = idlePulse_q;
  assign coreReset = coreReset_q;

  // ==========================================================
  // read data, one cycle after the strobe
  logic [7:0] rdMux;

  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      pwr_clk_pkg::OFF_CLOCK_CONTROL: rdMux = clockControl_q;
      pwr_clk_pkg::OFF_POWER_DOWN: rdMux[pwr_clk_pkg::PD_LOW_FREQ_BIT] = lfSync_q;
      pwr_clk_pkg::OFF_WAKEUP_CONFIG: rdMux = wakeupConfig_q;
      pwr_clk_pkg::OFF_POWER_CONTROL: rdMux = powerControl_q;
      pwr_clk_pkg::OFF_RESET_CAUSE: rdMux[pwr_clk_pkg::CAUSE_WATCHDOG_BIT] = watchdogCause_q;
      default: rdMux = 8'h00;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData <= pwr_clk_pkg::RST_READ_DATA;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= pwr_clk_pkg::RST_READ_DATA;
    end
  end

endmodule

// >>> tb/power_clock_wakeup_control_asserts.sv
// port checker for the power, clock and wakeup control block
`timescale 1ns/1ps

// ==========================================
// checker
module power_clock_wakeup_control_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // reset sources and usb state
  input wire logic resetPinN,
  input wire logic watchdogReset,
  input wire logic usbSuspended,
  // wakeup events
  input wire logic rfIrq,
  input wire logic internalWakeupEvent,
  input wire logic usbInterrupt,
  input wire logic usbResumeInterrupt,
  // outputs watched
  input wire logic pllOn,
  input wire logic [15:0] pllFreqKhz,
  input wire logic mcuClockRun,
  input wire logic coreReset,
  input wire logic stopModeReq,
  input wire logic idleModeReq
);
  logic noSrc;
  logic anyEv;
  logic [2:0] pinHist_q;

  // the block sees the pin two edges late, so its recent history must be high too
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinHist_q <= 3'h7;
    end else begin
      pinHist_q <= {pinHist_q[1:0], resetPinN};
    end
  end

  assign noSrc = resetPinN && (&pinHist_q) && !watchdogReset;
  assign anyEv = rfIrq | internalWakeupEvent | usbInterrupt | usbResumeInterrupt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_RD_IDLE: assert property (
    !$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
  AST_STOP_PULSE: assert property (
    regWr && regAddr == 8'h87 && noSrc |=> stopModeReq == $past(regWrData[1]))
    else $error("stop request not tied to write");
  AST_IDLE_PULSE: assert property (
    regWr && regAddr == 8'h87 && noSrc |=> idleModeReq == $past(regWrData[0]))
    else $error("idle request not tied to write");
  AST_PLL_HW: assert property (
    !$past(usbSuspended) |-> pllOn)
    else $error("pll off while usb active");
  AST_PLL_FREQ: assert property (
    $stable(pllOn) |-> pllFreqKhz == (pllOn ? 16'hBB80 : 16'h0000))
    else $error("pll frequency wrong");
  AST_STANDBY_ENTER: assert property (
    regWr && regAddr == 8'hA4 && regWrData[2:0] != 3'h0 && mcuClockRun && noSrc
    |=> !mcuClockRun)
    else $error("standby not entered");
  AST_ZERO_WRITE: assert property (
    regWr && regAddr == 8'hA4 && regWrData[2:0] == 3'h0 && mcuClockRun |=> mcuClockRun)
    else $error("zero write stopped clock");
  AST_NO_WAKE: assert property (
    !mcuClockRun && !anyEv && noSrc |=> !mcuClockRun)
    else $error("woke without event");
  AST_CORE_RESET: assert property (
    $fell(watchdogReset) && resetPinN |-> coreReset [*8] ##[8:16] !coreReset)
    else $error("start-up window wrong");

  // main scenarios reached
  cover property (!mcuClockRun ##1 mcuClockRun);
  cover property (stopModeReq && idleModeReq);
  cover property ($fell(pllOn));
endmodule

bind power_clock_wakeup_control power_clock_wakeup_control_asserts
  i_power_clock_wakeup_control_asserts (.*);

// >>> tb/core_irq_model.sv
// interrupt sources and slow clock on the core side of the block
`timescale 1ns/1ps

module core_irq_model #(
  parameter int LF_HALF = 16
) (
  // clock and bench commands
  input wire logic mclk,
  input wire logic [3:0] raiseMask,
  input wire logic clearAll,
  // far-side levels
  output logic lowFreqClock,
  output logic rfIrq,
  output logic internalWakeupEvent,
  output logic usbInterrupt,
  output logic usbResumeInterrupt
);
  int lfCount = 0;
  logic [3:0] pend = 4'h0;

  initial lowFreqClock = 1'b0;

  // slow clock never stops; half period shortened to keep runs brief
  always @(posedge mclk) begin
    lfCount <= (lfCount == LF_HALF - 1) ? 0 : lfCount + 1;
    if (lfCount == LF_HALF - 1) begin
      lowFreqClock <= ~lowFreqClock;
    end
  end

  // events stay pending until firmware clears them before standby
  always @(posedge mclk) begin
    pend <= clearAll ? 4'h0 : (pend | raiseMask);
  end
  assign {usbResumeInterrupt, usbInterrupt, internalWakeupEvent, rfIrq} = pend;
endmodule

// >>> tb/power_clock_wakeup_control_tb_top.sv
// self-checking bench for the power, clock and wakeup control block
`timescale 1ns/1ps

module power_clock_wakeup_control_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic resetPinN = 1'b1;
  logic watchdogReset = 1'b0;
  logic usbSuspended = 1'b0;
  logic [7:0] interruptEnableSecond = 8'h00;
  logic [3:0] raiseMask = 4'h0;
  logic clearAll = 1'b0;
  logic [7:0] regRdData;
  logic lowFreqClock, rfIrq, internalWakeupEvent, usbInterrupt, usbResumeInterrupt;
  logic pllOn, mcuClockRun, coreReset, baudDouble, progWriteEnable;
  logic stopModeReq, idleModeReq;
  logic [15:0] pllFreqKhz, mcuFreqKhz;
  logic [7:0] rdv;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;

  power_clock_wakeup_control i_power_clock_wakeup_control (.*);
  core_irq_model i_core_irq_model (.*);

  // ==========================================
  // bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    rdv = regRdData;
  endtask

  // bounded wait for the start-up window to close
  task automatic settle;
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk(coreReset, 1'b0);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [7:0] adr [5] = '{8'h87, 8'hA3, 8'hA4, 8'hA5, 8'hB1};
    logic [7:0] exv [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(adr[i]);
      chk(rdv & 8'hF7, exv[i]);
    end
    chk(pllOn, 1'b1);
    chk(pllFreqKhz, 16'hBB80);
    chk(mcuFreqKhz, pwr_clk_pkg::F16M_KHZ);
    wr(8'h00, 8'hFF);
    rd(8'h00);
    chk(rdv, 8'h00);
  endtask

  task automatic t_lowfreq;
    @(posedge lowFreqClock);
    tick(4);
    rd(8'hA4);
    chk(rdv, 8'h08);
    @(negedge lowFreqClock);
    tick(4);
    rd(8'hA4);
    chk(rdv, 8'h00);
  endtask

  task automatic t_power_control;
    wr(8'h87, 8'hFF);
    chk({stopModeReq, idleModeReq}, 2'b11);
    tick(1);
    chk({stopModeReq, idleModeReq}, 2'b00);
    chk({baudDouble, progWriteEnable}, 2'b11);
    rd(8'h87);
    chk(rdv, 8'hFC);
    wr(8'h87, 8'h00);
    rd(8'h87);
    chk(rdv, 8'h00);
    chk({baudDouble, progWriteEnable}, 2'b00);
  endtask

  task automatic t_wake;
    int lo [4] = '{6, 4, 2, 0};
    int ien [4] = '{1, 5, 4, 3};
    logic [1:0] md [5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1};
    logic en [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] cfg;
    wr(8'hA4, 8'h00);
    tick(1);
    chk(mcuClockRun, 1'b1);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 5; c++) begin
        cfg = 8'hFF;
        cfg[lo[s] +: 2] = md[c];
        wr(8'hA5, cfg);
        @(posedge mclk);
        interruptEnableSecond <= en[c] ? (8'h01 << ien[s]) : 8'h00;
        wr(8'hA4, 8'h04);
        chk(mcuClockRun, 1'b0);
        @(posedge mclk);
        raiseMask <= 4'h1 << s;
        @(posedge mclk);
        raiseMask <= 4'h0;
        tick(4);
        chk(mcuClockRun, ex[c]);
        if (!ex[c]) begin
          wr(8'hA5, 8'hAA);
          tick(1);
          chk(mcuClockRun, 1'b1);
        end
        chk(mcuFreqKhz, pwr_clk_pkg::F16M_KHZ);
        @(posedge mclk);
        clearAll <= 1'b1;
        @(posedge mclk);
        clearAll <= 1'b0;
      end
    end
  endtask

  task automatic t_clock;
    logic [15:0] pf [6] = '{pwr_clk_pkg::F16M_KHZ, pwr_clk_pkg::F12M_KHZ,
      pwr_clk_pkg::F8M_KHZ, pwr_clk_pkg::F4M_KHZ, pwr_clk_pkg::F1M6_KHZ,
      pwr_clk_pkg::F1M6_KHZ};
    logic [15:0] of [4] = '{pwr_clk_pkg::F4M_KHZ, pwr_clk_pkg::F1M6_KHZ,
      pwr_clk_pkg::F320K_KHZ, pwr_clk_pkg::F64K_KHZ};
    // last pll entry is a reserved code, which keeps the previous rate
    for (int c = 0; c < 6; c++) begin
      wr(8'hA3, {1'b1, 3'(c), 4'h0});
      tick(1);
      chk(mcuFreqKhz, pf[c]);
    end
    @(posedge mclk);
    usbSuspended <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'hA3, {6'h00, 2'(c)});
      tick(2);
      chk(mcuFreqKhz, of[c]);
    end
    chk(pllOn, 1'b0);
    chk(pllFreqKhz, 16'h0000);
    @(posedge mclk);
    usbSuspended <= 1'b0;
    tick(2);
    chk(pllOn, 1'b1);
    chk(pllFreqKhz, 16'hBB80);
  endtask

  task automatic t_resets;
    wr(8'hA5, 8'h55);
    @(posedge mclk);
    watchdogReset <= 1'b1;
    @(posedge mclk);
    watchdogReset <= 1'b0;
    tick(2);
    settle;
    rd(8'hB1);
    chk(rdv, 8'h01);
    rd(8'hA5);
    chk(rdv, 8'h00);
    wr(8'hB1, 8'h00);
    rd(8'hB1);
    chk(rdv, 8'h01);
    wr(8'hA3, 8'h30);
    @(posedge mclk);
    resetPinN <= 1'b0;
    tick(4);
    @(posedge mclk);
    resetPinN <= 1'b1;
    tick(3);
    settle;
    rd(8'hB1);
    chk(rdv, 8'h00);
    rd(8'hA3);
    chk(rdv, 8'h80);
  endtask

  // ==========================================
  // closing report
  task automatic test_done;
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    settle;
    t_reset;
    t_lowfreq;
    t_power_control;
    t_wake;
    t_clock;
    t_resets;
    test_done;
  end
endmodule
